// File: rtl/ui_arbiter_cfg.svh
// constants for the operator interface arbiter: offsets, fields, resets, timing
// assumes 100 MHz system clock and byte-addressed 32-bit classic Wishbone
`ifndef UI_ARBITER_CFG_SVH
`define UI_ARBITER_CFG_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_PW_LO       8'h04
`define OFS_PW_HI       8'h08
`define OFS_STATUS      8'h0C

// control register fields
`define CTRL_PROT_LSB   0
`define CTRL_PANEL_BIT  2
`define CTRL_REL_BIT    3

// protection choices
`define PROT_NONE       2'h0
`define PROT_COM        2'h1
`define PROT_MODEM      2'h2
`define PROT_BOTH       2'h3

// reset values
`define RST_PROT        2'h0
`define RST_PANEL_EN    1'b1
`define RST_PW          64'h0000_0000_0000_0000

// interface indices
`define IF_PANEL        2'h0
`define IF_COM          2'h1
`define IF_MODEM        2'h2
`define IF_SHELF        2'h3

// password layout
`define PW_LEN          8
`define PW_CHARS        7'h42

// timing
`define CLK_PERIOD_NS   40'd10
`define IDLE_TIME_S     40'd300
`define PW_TIME_S       40'd300
`define IDLE_CYCLES     (`IDLE_TIME_S * 40'd1000000000 / `CLK_PERIOD_NS)
`define PW_CYCLES       (`PW_TIME_S * 40'd1000000000 / `CLK_PERIOD_NS)
`define CNT_W           36

`endif

// File: rtl/ui_arbiter_pkg.sv
// types for the operator interface arbiter
// assumes ui_arbiter_cfg.svh for widths
`default_nettype none
`include "ui_arbiter_cfg.svh"

package ui_arbiter_pkg;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_FREE   = 3'b010,
    ST_PASSWD = 3'b100
  } arb_state_t;

  typedef enum logic [2:0] {
    KEY_OTHER   = 3'h0,
    KEY_UP      = 3'h1,
    KEY_DOWN    = 3'h2,
    KEY_LEFT    = 3'h3,
    KEY_RIGHT   = 3'h4,
    KEY_DONE    = 3'h5,
    KEY_RELEASE = 3'h6
  } key_t;

  typedef enum logic [2:0] {
    MSG_NONE      = 3'h0,
    MSG_MENU      = 3'h1,
    MSG_IN_USE    = 3'h2,
    MSG_AVAILABLE = 3'h3,
    MSG_RELEASED  = 3'h4,
    MSG_PROMPT    = 3'h5,
    MSG_INVALID   = 3'h6
  } msg_t;

  typedef struct packed {
    arb_state_t            state;
    logic [3:0]            active;
    logic [1:0]            owner;
    logic [`CNT_W-1:0]     cnt;
    logic [2:0]            cursor;
    logic [7:0][6:0]       entry;
    logic [3:0][2:0]       msg;
    logic [3:0]            key_prev;
    logic [3:0]            link_prev;
    logic [1:0]            prot;
    logic                  panel_en;
    logic [7:0][7:0]       pw;
    logic                  ack;
    logic [31:0]           rdat;
  } arb_regs_t;

endpackage

`default_nettype wire

// File: rtl/sync2.sv
// two-stage synchroniser for a bus of independent levels
// assumes each bit is a level that stays long enough to be sampled
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: rtl/ui_arbiter.sv
// operator interface arbiter: one of panel, console, modem or shelf port holds control
// assumes pin inputs asynchronous to clk; registers on classic Wishbone
//
// Behaviour
// - panel, console, modem (standalone) and shelf port (carrier) can each take control.
// - at most one interface active; input from others never changes control, only their own message.
// - reset makes the front panel the active interface.
// - download in progress or terminal link failure forces the panel active.
// - five idle minutes on the active interface release it for others.
// - release command frees control and shows released on that interface.
// - connection break on the active interface frees control.
// - taking control shows the top-level menu on the new interface.
// - input on an inactive interface while control is held shows in-use.
// - after release none is active until input; waiting interfaces see available.
// - protection setting none, console, modem or both; default none.
// - a protected port gets control only after a correct password.
// - passwords up to 8 characters; protected access prompts for one.
// - password characters are digits, letters, hash, hyphen, period, slash.
// - stored password defaults to nulls; empty entry then completes at once.
// - stored password never shown; only the entry cursor, starting at first place.
// - cursor moves right only over an entered character; left is not destructive.
// - password not completed within five minutes ends the session.
// - wrong password shows invalid and withholds control.
// - panel display and input gate, enabled by default.
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "ui_arbiter_cfg.svh"

module ui_arbiter
  import ui_arbiter_pkg::*;
#(
  parameter logic [`CNT_W-1:0] IDLE_CYC = `CNT_W'(`IDLE_CYCLES),
  parameter logic [`CNT_W-1:0] PW_CYC   = `CNT_W'(`PW_CYCLES)
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  key_req,
  input  wire logic [11:0] key_code,
  input  wire logic [3:0]  link_up,
  input  wire logic        download_active,
  input  wire logic        term_link_fail,
  input  wire logic        carrier_mounted,
  output logic      [3:0]  active_if,
  output logic      [1:0]  owner_if,
  output logic      [2:0]  pw_cursor,
  output logic      [11:0] iface_msg,
  output logic             panel_display_gate
);
  import ui_arbiter_pkg::*;

  localparam int SW = 23;

  arb_regs_t     r_q;
  arb_regs_t     r_d;
  logic [SW-1:0] sync_s;
  logic [3:0]    kreq_s;
  logic [11:0]   kcode_s;
  logic [3:0]    link_s;
  logic          dl_s;
  logic          fail_s;
  logic          carrier_s;

  // every pin level through two flops; codes ride with their request
  sync2 #(.W(SW)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({key_req, key_code, link_up, download_active, term_link_fail, carrier_mounted}),
    .q     (sync_s)
  );

  assign {kreq_s, kcode_s, link_s, dl_s, fail_s, carrier_s} = sync_s;

  // entry index to character: 0 null, 1..66 the accepted set
  function automatic logic [7:0] idx_to_char(input logic [6:0] idx);
    logic [7:0] c;
    c = 8'h00;
    if (idx >= 7'h01 && idx <= 7'h0A) c = 8'h30 + {1'b0, idx} - 8'h01;
    else if (idx >= 7'h0B && idx <= 7'h24) c = 8'h61 + {1'b0, idx} - 8'h0B;
    else if (idx >= 7'h25 && idx <= 7'h3E) c = 8'h41 + {1'b0, idx} - 8'h25;
    else if (idx == 7'h3F) c = 8'h23;
    else if (idx == 7'h40) c = 8'h2D;
    else if (idx == 7'h41) c = 8'h2E;
    else if (idx == 7'h42) c = 8'h2F;
    return c;
  endfunction

  // null or one of the accepted password characters
  function automatic logic char_ok(input logic [7:0] c);
    return (c == 8'h00) || (c >= 8'h30 && c <= 8'h39) || (c >= 8'h61 && c <= 8'h7A) ||
           (c >= 8'h41 && c <= 8'h5A) || c == 8'h23 || c == 8'h2D || c == 8'h2E || c == 8'h2F;
  endfunction

  function automatic logic [2:0] code_at(input logic [11:0] codes, input logic [1:0] i);
    logic [2:0] k;
    case (i)
      2'h0:    k = codes[2:0];
      2'h1:    k = codes[5:3];
      2'h2:    k = codes[8:6];
      default: k = codes[11:9];
    endcase
    return k;
  endfunction

  function automatic logic [3:0] onehot4(input logic [1:0] i);
    return 4'h1 << i;
  endfunction

  logic [3:0] usable;
  logic [3:0] key_hit;
  logic [3:0] conn_up;
  logic [3:0] conn_dn;
  logic [3:0] req;
  logic [1:0] req_idx;
  logic       req_any;
  logic       own_key;
  logic [2:0] own_code;
  logic       protected_req;
  logic       pw_match;
  logic       wr;
  logic       rd;
  logic [5:0] widx;

  always_comb begin
    r_d     = r_q;
    r_d.ack = 1'b0;

    // port set follows how the unit is mounted
    usable[`IF_PANEL] = r_q.panel_en;
    usable[`IF_COM]   = 1'b1;
    usable[`IF_MODEM] = !carrier_s;
    usable[`IF_SHELF] = carrier_s;

    // a rising request is one press; unusable ports are deaf
    key_hit     = kreq_s & ~r_q.key_prev & usable;
    conn_up     = link_s & ~r_q.link_prev & usable;
    conn_dn     = ~link_s & r_q.link_prev;
    // the panel has no connection that can break
    conn_dn[`IF_PANEL] = 1'b0;
    r_d.key_prev  = kreq_s;
    r_d.link_prev = link_s;
    req = key_hit | conn_up;

    // lowest index wins when several ask in one cycle
    req_any = |req;
    req_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) req_idx = 2'(i);
    end

    own_key  = key_hit[r_q.owner];
    own_code = code_at(kcode_s, r_q.owner);

    protected_req = (req_idx == `IF_COM   && r_q.prot[0]) ||
                    (req_idx == `IF_MODEM && r_q.prot[1]);

    // untouched places stay null and match a null stored char
    pw_match = 1'b1;
    for (int i = 0; i < `PW_LEN; i++) begin
      if (idx_to_char(r_q.entry[i]) != r_q.pw[i]) pw_match = 1'b0;
    end

    // bus access, taken in the cycle before ack
    wr   = wb_cyc_i && wb_stb_i && wb_we_i && !r_q.ack;
    rd   = wb_cyc_i && wb_stb_i && !wb_we_i && !r_q.ack;
    widx = wb_adr_i[7:2];
    r_d.ack = wb_cyc_i && wb_stb_i && !r_q.ack;
    if (rd) begin
      case ({widx, 2'b00})
        `OFS_CTRL:   r_d.rdat = {29'h0, r_q.panel_en, r_q.prot};
        `OFS_STATUS: r_d.rdat = {19'h0, carrier_s, r_q.cursor, r_q.owner, r_q.state, r_q.active};
        default:     r_d.rdat = 32'h0000_0000;
      endcase
    end
    if (wr && {widx, 2'b00} == `OFS_CTRL && wb_sel_i[0]) begin
      r_d.prot     = wb_dat_i[`CTRL_PROT_LSB +: 2];
      r_d.panel_en = wb_dat_i[`CTRL_PANEL_BIT];
    end
    // bytes outside the password set are dropped one by one
    for (int b = 0; b < 4; b++) begin
      if (wr && wb_sel_i[b] && char_ok(wb_dat_i[b*8 +: 8])) begin
        if ({widx, 2'b00} == `OFS_PW_LO) r_d.pw[b]   = wb_dat_i[b*8 +: 8];
        if ({widx, 2'b00} == `OFS_PW_HI) r_d.pw[b+4] = wb_dat_i[b*8 +: 8];
      end
    end

    // one counter serves both the idle and the entry timeout
    r_d.cnt = r_q.cnt + `CNT_W'(1);

    case (r_q.state)
      ST_ACTIVE: begin
        // others only ever see in-use while control is held, except a disabled panel, which shows none
        for (int i = 0; i < 4; i++) begin
          if (req[i] && 2'(i) != r_q.owner) r_d.msg[i] = MSG_IN_USE;
        end
        if (own_key) begin
          r_d.cnt = '0;
        end
        if ((own_key && own_code == KEY_RELEASE) ||
            (wr && {widx, 2'b00} == `OFS_CTRL && wb_sel_i[0] && wb_dat_i[`CTRL_REL_BIT])) begin
          r_d.state  = ST_FREE;
          r_d.active = 4'h0;
          r_d.msg    = {4{MSG_AVAILABLE}};
          r_d.msg[r_q.owner] = MSG_RELEASED;
        end else if (!own_key && r_q.cnt >= IDLE_CYC - `CNT_W'(1)) begin
          r_d.state  = ST_FREE;
          r_d.active = 4'h0;
          r_d.msg    = {4{MSG_AVAILABLE}};
          r_d.msg[r_q.owner] = MSG_RELEASED;
        end else if (conn_dn[r_q.owner]) begin
          r_d.state  = ST_FREE;
          r_d.active = 4'h0;
          r_d.msg    = {4{MSG_AVAILABLE}};
          r_d.msg[r_q.owner] = MSG_NONE;
        end
      end
      ST_FREE: begin
        // nobody active: the first asker takes over or is prompted
        r_d.cnt = '0;
        if (req_any && protected_req) begin
          r_d.state  = ST_PASSWD;
          r_d.owner  = req_idx;
          r_d.cursor = 3'h0;
          r_d.entry  = '0;
          r_d.msg[req_idx] = MSG_PROMPT;
        end else if (req_any) begin
          r_d.state  = ST_ACTIVE;
          r_d.owner  = req_idx;
          r_d.active = onehot4(req_idx);
          r_d.msg    = {4{MSG_IN_USE}};
          r_d.msg[req_idx] = MSG_MENU;
        end
      end
      ST_PASSWD: begin
        // timeout or a break leaves nobody active
        for (int i = 0; i < 4; i++) begin
          if (req[i] && 2'(i) != r_q.owner) r_d.msg[i] = MSG_IN_USE;
        end
        if (r_q.cnt >= PW_CYC - `CNT_W'(1) || conn_dn[r_q.owner]) begin
          r_d.state  = ST_FREE;
          r_d.entry  = '0;
          r_d.cursor = 3'h0;
          r_d.msg    = {4{MSG_AVAILABLE}};
          r_d.msg[r_q.owner] = MSG_NONE;
        end else if (own_key) begin
          case (own_code)
            KEY_UP: begin
              r_d.entry[r_q.cursor] = (r_q.entry[r_q.cursor] >= `PW_CHARS) ? 7'h01
                                      : r_q.entry[r_q.cursor] + 7'h01;
            end
            KEY_DOWN: begin
              r_d.entry[r_q.cursor] = (r_q.entry[r_q.cursor] <= 7'h01) ? `PW_CHARS
                                      : r_q.entry[r_q.cursor] - 7'h01;
            end
            KEY_LEFT: begin
              if (r_q.cursor != 3'h0) r_d.cursor = r_q.cursor - 3'h1;
            end
            KEY_RIGHT: begin
              if (r_q.entry[r_q.cursor] != 7'h00 && r_q.cursor != 3'h7) begin
                r_d.cursor = r_q.cursor + 3'h1;
              end
            end
            KEY_DONE: begin
              // the entry is wiped whatever the outcome
              r_d.entry  = '0;
              r_d.cursor = 3'h0;
              if (pw_match) begin
                r_d.state  = ST_ACTIVE;
                r_d.active = onehot4(r_q.owner);
                r_d.cnt    = '0;
                r_d.msg    = {4{MSG_IN_USE}};
                r_d.msg[r_q.owner] = MSG_MENU;
              end else begin
                r_d.state = ST_FREE;
                r_d.msg   = {4{MSG_AVAILABLE}};
                r_d.msg[r_q.owner] = MSG_INVALID;
              end
            end
            default: begin
              r_d.cnt = r_q.cnt + `CNT_W'(1);
            end
          endcase
        end
      end
      default: begin
        r_d.state = ST_FREE;
      end
    endcase

    if (!r_q.panel_en) r_d.msg[`IF_PANEL] = MSG_NONE;

    // download or link failure overrides all else each cycle
    if (dl_s || fail_s) begin
      r_d.state  = ST_ACTIVE;
      r_d.owner  = `IF_PANEL;
      r_d.active = onehot4(`IF_PANEL);
      r_d.cnt    = '0;
      r_d.entry  = '0;
      r_d.cursor = 3'h0;
      if (r_q.state != ST_ACTIVE || r_q.owner != `IF_PANEL) begin
        r_d.msg = {4{MSG_IN_USE}};
        r_d.msg[`IF_PANEL] = MSG_MENU;
      end
    end
  end

  // reset hands control back to the panel
  always_ff @(posedge clk) begin
    if (reset) begin
      r_q          <= '0;
      r_q.state    <= ST_ACTIVE;
      r_q.owner    <= `IF_PANEL;
      r_q.active   <= 4'h1;
      r_q.msg      <= {MSG_IN_USE, MSG_IN_USE, MSG_IN_USE, MSG_MENU};
      r_q.prot     <= `RST_PROT;
      r_q.panel_en <= `RST_PANEL_EN;
      r_q.pw       <= `RST_PW;
      r_q.ack      <= 1'b0;
      r_q.rdat     <= 32'h0000_0000;
      r_q.cursor   <= 3'h0;
    end else begin
      r_q <= r_d;
    end
  end

  // registered outputs, straight from the state
  assign wb_dat_o           = r_q.rdat;
  assign wb_ack_o           = r_q.ack;
  assign active_if          = r_q.active;
  assign owner_if           = r_q.owner;
  assign pw_cursor          = r_q.cursor;
  assign iface_msg          = r_q.msg;
  assign panel_display_gate = r_q.panel_en;

endmodule

`default_nettype wire

// File: sim/ui_arbiter_asserts.sv
// port checker for the operator interface arbiter
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module ui_arbiter_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        download_active,
  input wire logic [3:0]  active_if,
  input wire logic [1:0]  owner_if,
  input wire logic [2:0]  pw_cursor,
  input wire logic [11:0] iface_msg,
  input wire logic        panel_display_gate
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_state: assert property ($fell(reset) |-> active_if == 4'h1 && iface_msg == 12'h491 && panel_display_gate)
    else $error("state after reset wrong");
  a_one_active: assert property ($onehot0(active_if))
    else $error("more than one interface active");
  a_forced_panel: assert property (download_active [*4] |=> active_if == 4'h1)
    else $error("panel not forced during download");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  a_menu_take: assert property ($rose(active_if[1]) |-> iface_msg[5:3] == 3'h1)
    else $error("no top menu on new owner");
  a_prompt_cursor: assert property (iface_msg[5:3] == 3'h5 && $past(iface_msg[5:3]) != 3'h5 |-> pw_cursor == 3'h0)
    else $error("prompt cursor not at first place");
  a_cursor_step: assert property ($changed(pw_cursor) |-> pw_cursor == 3'h0 ||
      pw_cursor == $past(pw_cursor) + 3'h1 || pw_cursor == $past(pw_cursor) - 3'h1)
    else $error("cursor jumped");
  c_console_owner: cover property (active_if == 4'h2 && owner_if == 2'h1);
  c_invalid: cover property (iface_msg[5:3] == 3'h6);
  c_released: cover property (active_if == 4'h0 && iface_msg[2:0] == 3'h4);
endmodule
bind ui_arbiter ui_arbiter_asserts i_chk (
  .clk                (clk),
  .reset              (reset),
  .wb_cyc_i           (wb_cyc_i),
  .wb_stb_i           (wb_stb_i),
  .wb_ack_o           (wb_ack_o),
  .download_active    (download_active),
  .active_if          (active_if),
  .owner_if           (owner_if),
  .pw_cursor          (pw_cursor),
  .iface_msg          (iface_msg),
  .panel_display_gate (panel_display_gate)
);
`default_nettype wire

// File: sim/operator_side_model.sv
// operators at the four interfaces: key presses and connection levels
// assumes the bench calls press and set_link from one thread
`timescale 1ns/10ps
`default_nettype none
module operator_side_model (
  input  wire logic        clk,
  output logic      [3:0]  key_req,
  output logic      [11:0] key_code,
  output logic      [3:0]  link_up
);
  initial begin
    key_req = 4'h0;
    key_code = 12'h000;
    link_up = 4'hF;
  end
  // code settles with the rising request, then scrambles after release
  task automatic press(input int i, input logic [2:0] c);
    @(posedge clk);
    key_code[i*3 +: 3] <= c;
    key_req[i] <= 1'b1;
    repeat (3) @(posedge clk);
    key_req[i] <= 1'b0;
    key_code[i*3 +: 3] <= ~c;
    repeat (4) @(posedge clk);
  endtask
  task automatic set_link(input int i, input logic v);
    @(posedge clk);
    link_up[i] <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: sim/user_interface_access_arbiter_bench.sv
// self-checking bench for the operator interface arbiter
// assumes short idle and password counts, console on a standalone unit
`timescale 1ns/10ps
`default_nettype none
`include "ui_arbiter_cfg.svh"
module user_interface_access_arbiter_bench;
  import ui_arbiter_pkg::*;
  localparam int T_CNT = 200;
  logic clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, gate, dl, tlf, carrier;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_rdat, r;
  logic [3:0] key_req, link_up, active_if, wb_sel;
  logic [11:0] key_code, iface_msg;
  logic [1:0] owner_if;
  logic [2:0] pw_cursor;
  int num_errors = 0;
  int n_compared = 0;
  ui_arbiter #(.IDLE_CYC(`CNT_W'(T_CNT)), .PW_CYC(`CNT_W'(T_CNT))) i_dut (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .key_req(key_req), .key_code(key_code), .link_up(link_up), .download_active(dl),
    .term_link_fail(tlf), .carrier_mounted(carrier), .active_if(active_if), .owner_if(owner_if),
    .pw_cursor(pw_cursor), .iface_msg(iface_msg), .panel_display_gate(gate));
  operator_side_model i_ops (.clk(clk), .key_req(key_req), .key_code(key_code), .link_up(link_up));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      chk("bus ack", 0, 1);
      report_and_stop();
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic look(input logic [3:0] act, input int lane, input logic [2:0] m);
    chk("active_if", active_if, act);
    chk("iface_msg", iface_msg[lane*3 +: 3], m);
  endtask
  task automatic t_reset();
    look(4'h1, 0, MSG_MENU);
    chk("gate", gate, 1);
    wb(0, `OFS_CTRL, 0);
    chk("ctrl", r, 32'h4);
    wb(1, `OFS_CTRL, 32'h0, 4'hE);
    wb(0, `OFS_CTRL, 0);
    chk("ctrl sel", r, 32'h4);
    wb(0, 8'h10, 0);
    chk("unmapped", r, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_take();
    wb(1, `OFS_CTRL, 32'hC);
    look(4'h0, 0, MSG_RELEASED);
    chk("waiting", iface_msg[5:3], MSG_AVAILABLE);
    i_ops.press(1, KEY_OTHER);
    look(4'h2, 1, MSG_MENU);
    chk("owner_if", owner_if, 1);
    i_ops.press(0, KEY_OTHER);
    look(4'h2, 0, MSG_IN_USE);
    i_ops.set_link(1, 1'b0);
    look(4'h0, 1, MSG_NONE);
    i_ops.set_link(1, 1'b1);
    look(4'h2, 1, MSG_MENU);
    $display("test take and break done");
  endtask
  task automatic t_idle();
    i_ops.press(1, KEY_RELEASE);
    look(4'h0, 1, MSG_RELEASED);
    i_ops.press(1, KEY_OTHER);
    repeat (150) @(posedge clk);
    i_ops.press(1, KEY_OTHER);
    repeat (150) @(posedge clk);
    chk("active_if", active_if, 4'h2);
    repeat (100) @(posedge clk);
    look(4'h0, 1, MSG_RELEASED);
    $display("test idle done");
  endtask
  task automatic t_password();
    wb(1, `OFS_PW_LO, 32'h30);
    wb(1, `OFS_CTRL, 32'hD);
    i_ops.press(1, KEY_OTHER);
    look(4'h0, 1, MSG_PROMPT);
    chk("cursor", pw_cursor, 0);
    chk("owner_if", owner_if, 1);
    i_ops.press(1, KEY_RIGHT);
    chk("cursor", pw_cursor, 0);
    i_ops.press(1, KEY_DONE);
    look(4'h0, 1, MSG_INVALID);
    i_ops.press(1, KEY_OTHER);
    i_ops.press(1, KEY_UP);
    i_ops.press(1, KEY_DOWN);
    i_ops.press(1, KEY_UP);
    i_ops.press(1, KEY_RIGHT);
    chk("cursor", pw_cursor, 1);
    i_ops.press(1, KEY_LEFT);
    chk("cursor", pw_cursor, 0);
    i_ops.press(1, KEY_DONE);
    look(4'h2, 1, MSG_MENU);
    wb(1, `OFS_PW_LO, 32'h0);
    wb(1, `OFS_CTRL, 32'hD);
    i_ops.press(1, KEY_OTHER);
    i_ops.press(1, KEY_DONE);
    chk("active_if", active_if, 4'h2);
    wb(1, `OFS_CTRL, 32'hD);
    i_ops.press(1, KEY_OTHER);
    repeat (T_CNT + 10) @(posedge clk);
    wb(0, `OFS_STATUS, 0);
    chk("state", r[6:4], 3'b010);
    $display("test password done");
  endtask
  task automatic t_force_gate();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      dl <= (k == 0);
      tlf <= (k == 1);
      repeat (6) @(posedge clk);
      chk("forced", active_if, 4'h1);
      dl <= 1'b0;
      tlf <= 1'b0;
      repeat (4) @(posedge clk);
    end
    wb(1, `OFS_CTRL, 32'h8);
    chk("gate", gate, 0);
    i_ops.press(0, KEY_OTHER);
    chk("active_if", active_if, 4'h0);
    wb(1, `OFS_CTRL, 32'h4);
    chk("gate", gate, 1);
    $display("test force and gate done");
  endtask
  task automatic t_ports();
    wb(1, `OFS_CTRL, 32'h6);
    i_ops.press(2, KEY_OTHER);
    look(4'h0, 2, MSG_PROMPT);
    chk("owner_if", owner_if, 2);
    i_ops.press(2, KEY_DONE);
    look(4'h4, 2, MSG_MENU);
    wb(1, `OFS_CTRL, 32'hC);
    carrier <= 1'b1;
    i_ops.press(2, KEY_OTHER);
    chk("active_if", active_if, 4'h0);
    i_ops.press(3, KEY_OTHER);
    look(4'h8, 3, MSG_MENU);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    look(4'h1, 0, MSG_MENU);
    chk("owner_if", owner_if, 0);
    $display("test ports and reset done");
  endtask
  initial begin
    reset = 1'b1;
    {wb_cyc, wb_stb, wb_we, dl, tlf, carrier} = 6'h00;
    wb_sel = 4'h0;
    wb_adr = 8'h00;
    wb_dat = 32'h0000_0000;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_take();
    t_idle();
    t_password();
    t_force_gate();
    t_ports();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    chk("run time", 0, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
